/* msd_cfg.svh */
// Purpose: constants for the memory space decoder
// Assumes: included by bare name
// Notes: byte addresses unless stated
`ifndef MSD_CFG_SVH
`define MSD_CFG_SVH
`define MSD_PA_W 24
`define MSD_PC_W 23
`define MSD_EA_W 16
`define MSD_USER_TOP 24'h7fffff
`define MSD_RESET_ADDR 24'h000000
`define MSD_START_ADDR 24'h000002
`define MSD_IVT_LO 24'h000004
`define MSD_IVT_HI 24'h0000ff
`define MSD_AIVT_LO 24'h000100
`define MSD_AIVT_HI 24'h0001ff
`define MSD_VEC_END 24'h000200
`define MSD_CFG_LO 24'hf80000
`define MSD_CFG_HI 24'hf80017
`define MSD_DEVICE_ID_REGION_LO 24'hff0000
`define MSD_DEVICE_ID_REGION_HI 24'hfffffe
`define MSD_TPAG_CFG_BIT 7
`define MSD_PSV_BIT 15
`define MSD_RAM_BYTES 16384
`define MSD_PC_STEP 23'h000002
`endif

/* msd_pkg.sv */
// Purpose: types for the memory space decoder
// Assumes: nothing
// Notes: region codes shared by decoder and top
package msd_pkg;
  typedef enum logic [2:0] {
    MSD_PR_RESET, MSD_PR_IVT, MSD_PR_AIVT, MSD_PR_VRSV, MSD_PR_USER, MSD_PR_CFG,
    MSD_PR_DEVICE_ID_REGION, MSD_PR_DENY
  } msd_preg_t;
  typedef enum logic [1:0] {
    MSD_DR_RAM, MSD_DR_UNIMPL, MSD_DR_PSV, MSD_DR_PSVOFF
  } msd_dreg_t;
endpackage : msd_pkg

/* msd_dec_if.sv */
// Purpose: carrier between top and region decoder
// Assumes: msd_pkg compiled first
// Notes: purely combinational content
`timescale 1ns/1ps
interface msd_dec_if import msd_pkg::*; ();
  logic [23:0] p_addr;
  logic p_table;
  logic [7:0] p_tpage;
  msd_preg_t p_region;
  logic [15:0] rd_ea;
  logic [15:0] wr_ea;
  logic psv_en;
  msd_dreg_t rd_region;
  msd_dreg_t wr_region;
  modport top (output p_addr, p_table, p_tpage, rd_ea, wr_ea, psv_en,
    input p_region, rd_region, wr_region);
  modport dec (input p_addr, p_table, p_tpage, rd_ea, wr_ea, psv_en,
    output p_region, rd_region, wr_region);
endinterface : msd_dec_if

/* msd_region_dec.sv */
// Purpose: single-cycle region decode of program and data addresses
// Assumes: msd_cfg.svh constants
// Notes: no state
`timescale 1ns/1ps
`include "msd_cfg.svh"
module msd_region_dec import msd_pkg::*; #(
  parameter int RAM_BYTES = `MSD_RAM_BYTES
) (
  msd_dec_if.dec d
);
  if (RAM_BYTES < 2 || RAM_BYTES > `MSD_RAM_BYTES) begin : g_ram_range
    $error("bad RAM_BYTES");
  end
  localparam logic [15:0] RAM_TOP = 16'(RAM_BYTES);

  function automatic msd_dreg_t data_reg(input logic [15:0] ea, input logic en);
    if (!ea[`MSD_PSV_BIT]) begin
      data_reg = (ea < RAM_TOP) ? MSD_DR_RAM : MSD_DR_UNIMPL;
    end else begin
      data_reg = en ? MSD_DR_PSV : MSD_DR_PSVOFF;
    end
  endfunction : data_reg

  always_comb begin
    d.rd_region = data_reg(d.rd_ea, d.psv_en);
    d.wr_region = data_reg(d.wr_ea, d.psv_en);
    if (d.p_addr <= `MSD_USER_TOP) begin
      if (d.p_addr < `MSD_IVT_LO) begin
        d.p_region = MSD_PR_RESET;
      end else if (d.p_addr <= `MSD_IVT_HI) begin
        d.p_region = MSD_PR_IVT;
      end else if (d.p_addr <= `MSD_AIVT_HI) begin
        d.p_region = MSD_PR_AIVT;
      end else begin
        d.p_region = MSD_PR_USER;
      end
    end else if (d.p_table && d.p_tpage[`MSD_TPAG_CFG_BIT]) begin
      if (d.p_addr >= `MSD_CFG_LO && d.p_addr <= `MSD_CFG_HI) begin
        d.p_region = MSD_PR_CFG;
      end else if (d.p_addr >= `MSD_DEVICE_ID_REGION_LO) begin
        d.p_region = MSD_PR_DEVICE_ID_REGION;
      end else begin
        d.p_region = MSD_PR_DENY;
      end
    end else begin
      d.p_region = MSD_PR_DENY;
    end
  end
endmodule : msd_region_dec

/* msd_top.sv */
// Function
// - program addresses are 24 bits, from 23-bit counter or table/remap source
// - program space spans 4M instruction locations
// - ordinary fetches reach only 0x000000 to 0x7fffff
// - table ops reach configuration and id space only with page bit 7 set
// - even address is lower word, odd is upper word, top byte unused
// - program addresses stay word aligned; counter steps by two
// - addresses below 0x000200 hold reset, interrupt and trap vectors
// - fetching starts at 0x000000 after reset; jump target at 0x000002
// - primary vectors 0x000004-0x0000ff, alternate 0x000100-0x0001ff
// - read and write data addresses are generated independently
// - 16-bit byte effective addresses cover 64 Kbytes
// - bit 15 clear is data memory, set is program view window
// - at most 16 Kbytes ram; reads elsewhere return zero
// - words hold low byte at even, high byte at odd address
// - program view works only while the view enable is set
// - odd word access traps; read completes, write suppressed
////////////////////////////////////////////////////////////////////////////////
// Purpose: program counter and address decode for a 16-bit core
// Assumes: synchronous inputs, single clock, sync active high reset
// Notes: outputs registered, so decoded results show one edge after request
`timescale 1ns/1ps
`include "msd_cfg.svh"
module msd_top import msd_pkg::*; #(
  parameter int RAM_BYTES = `MSD_RAM_BYTES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pc_step,
  input wire logic pc_down,
  input wire logic pc_load,
  input wire logic [22:0] pc_load_val,
  input wire logic tbl_req,
  input wire logic tbl_write,
  input wire logic [7:0] table_page_register,
  input wire logic [15:0] tbl_offset,
  input wire logic tbl_upper,
  input wire logic psv_enable,
  input wire logic rd_req,
  input wire logic rd_word,
  input wire logic [15:0] rd_effective_address,
  input wire logic [15:0] mem_rd_data,
  input wire logic wr_req,
  input wire logic wr_word,
  input wire logic [15:0] wr_effective_address,
  input wire logic [15:0] wr_data,
  output logic [22:0] pc,
  output logic [23:0] prog_addr,
  output logic prog_upper,
  output msd_preg_t prog_region,
  output logic prog_ok,
  output logic [15:0] rd_data,
  output msd_dreg_t rd_region,
  output logic [23:0] psv_addr,
  output logic psv_rd,
  output logic ram_we_lo,
  output logic ram_we_hi,
  output logic [13:0] ram_waddr,
  output logic [15:0] ram_wdata,
  output logic addr_err_trap
);
  if (RAM_BYTES < 2 || RAM_BYTES > `MSD_RAM_BYTES) begin : g_ram_range
    $error("bad RAM_BYTES");
  end

  msd_dec_if dif ();
  msd_region_dec #(.RAM_BYTES(RAM_BYTES)) u_dec (.d(dif.dec));

  ////////////////////////////////////////////////////////////////////////////
  // program side
  logic [22:0] pc_r, pc_nxt;
  logic [23:0] paddr_r, paddr_nxt;
  logic pupper_r, pupper_nxt;
  msd_preg_t preg_r, preg_nxt;
  logic pok_r, pok_nxt;

  // a table request owns the program address for its cycle
  assign dif.p_addr = tbl_req ? {table_page_register, tbl_offset} : {1'b0, pc_r};
  assign dif.p_table = tbl_req;
  assign dif.p_tpage = table_page_register;

  always_comb begin
    pc_nxt = pc_r;
    if (pc_load) begin
      pc_nxt = {pc_load_val[22:1], 1'b0};
    end else if (pc_step) begin
      pc_nxt = pc_down ? pc_r - `MSD_PC_STEP : pc_r + `MSD_PC_STEP;
    end
    paddr_nxt = {dif.p_addr[23:1], 1'b0};
    pupper_nxt = tbl_req & tbl_upper;
    preg_nxt = dif.p_region;
    pok_nxt = (dif.p_region != MSD_PR_DENY);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pc_r <= 23'h000000;
      paddr_r <= 24'h000000;
      pupper_r <= 1'b0;
      preg_r <= MSD_PR_RESET;
      pok_r <= 1'b1;
    end else begin
      pc_r <= pc_nxt;
      paddr_r <= paddr_nxt;
      pupper_r <= pupper_nxt;
      preg_r <= preg_nxt;
      pok_r <= pok_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read generator
  logic [15:0] rdata_r, rdata_nxt;
  msd_dreg_t rreg_r, rreg_nxt;
  logic [23:0] psva_r, psva_nxt;
  logic psvrd_r, psvrd_nxt;
  logic rd_mis;

  assign dif.rd_ea = rd_effective_address;
  assign dif.psv_en = psv_enable;
  assign rd_mis = rd_req & rd_word & rd_effective_address[0];

  always_comb begin
    rdata_nxt = 16'h0000;
    if (rd_req && dif.rd_region == MSD_DR_RAM) begin
      // byte reads land in the low lane
      if (rd_word) begin
        rdata_nxt = mem_rd_data;
      end else begin
        rdata_nxt = {8'h00, rd_effective_address[0] ? mem_rd_data[15:8]
                                                    : mem_rd_data[7:0]};
      end
    end
    rreg_nxt = dif.rd_region;
    psvrd_nxt = rd_req & (dif.rd_region == MSD_DR_PSV);
    psva_nxt = {table_page_register[7:0], 1'b0, rd_effective_address[14:0]};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 16'h0000;
      rreg_r <= MSD_DR_RAM;
      psva_r <= 24'h000000;
      psvrd_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rreg_r <= rreg_nxt;
      psva_r <= psva_nxt;
      psvrd_r <= psvrd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write generator, independent of the read side
  logic [1:0] we_r, we_nxt;
  logic [13:0] wa_r, wa_nxt;
  logic [15:0] wd_r, wd_nxt;
  logic wr_mis;
  logic wr_hit;

  assign dif.wr_ea = wr_effective_address;
  assign wr_mis = wr_req & wr_word & wr_effective_address[0];
  // misaligned write still executes but never touches memory
  assign wr_hit = wr_req & ~wr_mis & (dif.wr_region == MSD_DR_RAM);

  // one enable per byte lane; lane index matches the address lsb
  for (genvar ln = 0; ln < 2; ln++) begin : g_lane
    assign we_nxt[ln] = wr_hit & (wr_word | (wr_effective_address[0] == 1'(ln)));
  end

  always_comb begin
    wa_nxt = wr_effective_address[14:1];
    // byte data shows on both lanes; the lane enable picks the one written
    wd_nxt = wr_word ? wr_data : {wr_data[7:0], wr_data[7:0]};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      we_r <= 2'h0;
      wa_r <= 14'h0000;
      wd_r <= 16'h0000;
    end else begin
      we_r <= we_nxt;
      wa_r <= wa_nxt;
      wd_r <= wd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address error trap from either generator
  logic trap_r, trap_nxt;

  always_comb begin
    // one trap even when both generators misalign together
    trap_nxt = rd_mis | wr_mis;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trap_r <= 1'b0;
    end else begin
      trap_r <= trap_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from their registers
  assign pc = pc_r;
  assign prog_addr = paddr_r;
  assign prog_upper = pupper_r;
  assign prog_region = preg_r;
  assign prog_ok = pok_r;
  assign rd_data = rdata_r;
  assign rd_region = rreg_r;
  assign psv_addr = psva_r;
  assign psv_rd = psvrd_r;
  assign ram_we_lo = we_r[0];
  assign ram_we_hi = we_r[1];
  assign ram_waddr = wa_r;
  assign ram_wdata = wd_r;
  assign addr_err_trap = trap_r;
endmodule : msd_top

/* msd_checker.sv */
// Purpose: port checks for msd_top
// Assumes: bound into msd_top, one clock
// Notes: outputs lag their inputs by one edge
`timescale 1ns/1ps
module msd_checker import msd_pkg::*; #(
  parameter int RAM_BYTES = 16384
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tbl_req,
  input wire logic [7:0] table_page_register,
  input wire logic [15:0] tbl_offset,
  input wire logic psv_enable,
  input wire logic rd_req,
  input wire logic rd_word,
  input wire logic [15:0] rd_effective_address,
  input wire logic wr_req,
  input wire logic wr_word,
  input wire logic [15:0] wr_effective_address,
  input wire logic [22:0] pc,
  input wire logic [23:0] prog_addr,
  input wire msd_preg_t prog_region,
  input wire logic prog_ok,
  input wire logic [15:0] rd_data,
  input wire msd_dreg_t rd_region,
  input wire logic psv_rd,
  input wire logic ram_we_lo,
  input wire logic ram_we_hi,
  input wire logic addr_err_trap
);
  logic err_c;
  assign err_c = rd_req && rd_word && rd_effective_address[0] ||
    wr_req && wr_word && wr_effective_address[0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  chk_reset_start: assert property ($fell(rst) |-> pc == 23'h0 && prog_addr == 24'h0)
    else $error("fetch not at zero after reset");
  chk_fetch_addr: assert property (!tbl_req |=> prog_ok && prog_addr == {1'b0, $past(pc)})
    else $error("fetch address wrong");
  chk_vector_map: assert property (prog_addr < 24'h200 |->
    prog_region == (prog_addr < 24'h4 ? MSD_PR_RESET : prog_addr < 24'h100 ? MSD_PR_IVT :
    MSD_PR_AIVT)) else $error("vector region wrong");
  chk_table_gate: assert property (tbl_req |=> prog_ok == (!$past(table_page_register[7]) ||
    $past(table_page_register) == 8'hff || $past(table_page_register) == 8'hf8 &&
    $past(tbl_offset) < 16'h18)) else $error("table gate wrong");
  chk_zero_fill: assert property (rd_req && rd_effective_address >= RAM_BYTES |=>
    rd_data == 16'h0) else $error("unmapped read not zero");
  chk_view_gate: assert property (rd_req && rd_effective_address[15] |=>
    psv_rd == $past(psv_enable) && rd_region == ($past(psv_enable) ? MSD_DR_PSV : MSD_DR_PSVOFF))
    else $error("view window gate wrong");
  chk_misalign_trap: assert property (1'b1 |=> addr_err_trap == $past(err_c))
    else $error("trap mismatch");
  chk_write_drop: assert property (wr_req && wr_word && wr_effective_address[0] |=>
    !ram_we_lo && !ram_we_hi) else $error("misaligned write reached ram");
endmodule : msd_checker

/* msd_ram_model.sv */
// Purpose: data ram on the decoder's memory side
// Assumes: word index from ram_waddr and read address
// Notes: 64 words only; aliasing is fine, decoder must gate far reads
`timescale 1ns/1ps
module msd_ram_model (
  input wire logic clk,
  input wire logic ram_we_lo,
  input wire logic ram_we_hi,
  input wire logic [13:0] ram_waddr,
  input wire logic [15:0] ram_wdata,
  input wire logic [15:0] rd_effective_address,
  output logic [15:0] mem_rd_data
);
  logic [15:0] mem [64];
  initial for (int i = 0; i < 64; i++) mem[i] = 16'h5a5a;
  assign mem_rd_data = mem[rd_effective_address[6:1]];
  always @(posedge clk) begin
    if (ram_we_lo) mem[ram_waddr[5:0]][7:0] <= ram_wdata[7:0];
    if (ram_we_hi) mem[ram_waddr[5:0]][15:8] <= ram_wdata[15:8];
  end
endmodule : msd_ram_model

/* testbench.sv */
// Purpose: self-checking bench for msd_top
// Assumes: package, ram model and checker compiled first
// Notes: inputs move 1 ns after an edge, results read one edge later
`timescale 1ns/1ps
module testbench import msd_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pc_step, pc_down, pc_load, tbl_req, tbl_write, tbl_upper, psv_enable, rd_req;
  logic rd_word, wr_req, wr_word, prog_upper, prog_ok, psv_rd, ram_we_lo, ram_we_hi;
  logic addr_err_trap;
  logic [22:0] pc_load_val, pc;
  logic [7:0] table_page_register;
  logic [15:0] tbl_offset, rd_effective_address, mem_rd_data, wr_effective_address, wr_data;
  logic [15:0] rd_data, ram_wdata;
  logic [23:0] prog_addr, psv_addr;
  logic [13:0] ram_waddr;
  msd_preg_t prog_region;
  msd_dreg_t rd_region;
  int failures = 0, check_count = 0, cycles = 0;
  // ok, region, address
  logic [27:0] tv [10] = '{28'h8000002, 28'h9000004, 28'h90000fe, 28'ha000100, 28'hc000200,
    28'hc7ffffe, 28'hdf80016, 28'h7f80018, 28'heff0000, 28'h7800000};
  // address, word, region, trap, data
  logic [35:0] rv [6] = '{36'h00108ab34, 36'h0011000ab, 36'h001000034, 36'h00119ab34,
    36'h4000a0000, 36'h8010e0000};
  ////////////////////////////////////////////////////////////
  msd_top #(.RAM_BYTES(16384)) DUT (
    .clk(clk), .rst(rst), .pc_step(pc_step), .pc_down(pc_down),
    .pc_load(pc_load), .pc_load_val(pc_load_val), .tbl_req(tbl_req), .tbl_write(tbl_write),
    .table_page_register(table_page_register), .tbl_offset(tbl_offset),
    .tbl_upper(tbl_upper), .psv_enable(psv_enable), .rd_req(rd_req), .rd_word(rd_word),
    .rd_effective_address(rd_effective_address), .mem_rd_data(mem_rd_data),
    .wr_req(wr_req), .wr_word(wr_word), .wr_effective_address(wr_effective_address),
    .wr_data(wr_data), .pc(pc), .prog_addr(prog_addr), .prog_upper(prog_upper),
    .prog_region(prog_region), .prog_ok(prog_ok), .rd_data(rd_data), .rd_region(rd_region),
    .psv_addr(psv_addr), .psv_rd(psv_rd), .ram_we_lo(ram_we_lo), .ram_we_hi(ram_we_hi),
    .ram_waddr(ram_waddr), .ram_wdata(ram_wdata), .addr_err_trap(addr_err_trap));
  msd_ram_model u_ram (.clk(clk), .ram_we_lo(ram_we_lo), .ram_we_hi(ram_we_hi),
    .ram_waddr(ram_waddr), .ram_wdata(ram_wdata),
    .rd_effective_address(rd_effective_address), .mem_rd_data(mem_rd_data));
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      print_verdict();
    end
  end
  task cyc;
    @(posedge clk);
    #1;
  endtask : cyc
  task chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task print_verdict;
    if (failures == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  task t_fetch;
    chk({pc, prog_addr, prog_ok, prog_region}, {23'h0, 24'h0, 1'b1, MSD_PR_RESET});
    pc_step = 1'b1;
    cyc;
    chk({pc, prog_addr}, {23'h2, 24'h0});
    cyc;
    chk({pc, prog_addr}, {23'h4, 24'h2});
    pc_down = 1'b1;
    cyc;
    chk({pc, prog_addr, prog_region}, {23'h2, 24'h4, MSD_PR_IVT});
    // odd target and step together: load must win, bit 0 dropped
    {pc_load, pc_load_val} = {1'b1, 23'h000101};
    cyc;
    chk(pc, 64'h100);
    {pc_step, pc_down, pc_load} = 3'h0;
    cyc;
    chk({prog_addr, prog_region}, {24'h100, MSD_PR_AIVT});
  endtask : t_fetch
  task t_table;
    tbl_req = 1'b1;
    for (int i = 0; i < 10; i++) begin
      {table_page_register, tbl_offset, tbl_upper, tbl_write} = {tv[i][23:0], i[1:0]};
      cyc;
      chk({prog_ok, prog_region, prog_addr}, tv[i]);
      chk(prog_upper, i[1]);
    end
    tbl_req = 1'b0;
  endtask : t_table
  task t_write;
    {wr_req, wr_word, wr_effective_address, wr_data} = {2'h3, 16'h0010, 16'h1234};
    {rd_req, rd_word, rd_effective_address} = {2'h3, 16'h0020};
    cyc;
    chk({ram_we_hi, ram_we_lo, ram_waddr, ram_wdata}, {2'h3, 14'h8, 16'h1234});
    chk({rd_data, rd_region}, {16'h5a5a, MSD_DR_RAM});
    {wr_word, wr_effective_address, wr_data, rd_req} = {1'b0, 16'h0011, 16'h00ab, 1'b0};
    cyc;
    chk({ram_we_hi, ram_we_lo, ram_wdata}, {2'h2, 16'habab});
    {wr_word, wr_effective_address} = {1'b1, 16'h0013};
    cyc;
    chk({addr_err_trap, ram_we_hi, ram_we_lo}, 3'h4);
    wr_req = 1'b0;
    cyc;
  endtask : t_write
  task t_read;
    rd_req = 1'b1;
    for (int i = 0; i < 6; i++) begin
      {rd_effective_address, rd_word} = rv[i][35:19];
      cyc;
      chk({rd_region, addr_err_trap, rd_data}, rv[i][18:0]);
    end
    {table_page_register, psv_enable, rd_word, rd_effective_address} = {8'h12, 2'h3, 16'h8010};
    cyc;
    chk({psv_addr, psv_rd, rd_region, rd_data}, {24'h120010, 1'b1, MSD_DR_PSV, 16'h0});
    rd_req = 1'b0;
  endtask : t_read
  task t_reset;
    cyc;
    {pc_step, rd_req, rd_word, rd_effective_address} = {3'h7, 16'h0010};
    cyc;
    rst = 1'b1;
    cyc;
    chk({pc, prog_addr, prog_ok, prog_region}, {23'h0, 24'h0, 1'b1, MSD_PR_RESET});
    chk({rd_data, addr_err_trap, ram_we_hi, ram_we_lo}, 19'h0);
    rst = 1'b0;
    cyc;
    chk({pc, prog_addr}, {23'h2, 24'h0});
    {pc_step, rd_req} = 2'h0;
  endtask : t_reset
  initial begin
    {pc_step, pc_down, pc_load, tbl_req, tbl_write, tbl_upper, psv_enable, rd_req} = 8'h0;
    {rd_word, wr_req, wr_word, pc_load_val, table_page_register, tbl_offset} = '0;
    {rd_effective_address, wr_effective_address, wr_data} = '0;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    t_fetch;
    t_table;
    t_write;
    t_read;
    t_reset;
    print_verdict;
  end
endmodule : testbench
bind msd_top msd_checker #(.RAM_BYTES(RAM_BYTES)) u_chk (.clk(clk), .rst(rst),
  .tbl_req(tbl_req), .table_page_register(table_page_register), .tbl_offset(tbl_offset),
  .psv_enable(psv_enable), .rd_req(rd_req), .rd_word(rd_word),
  .rd_effective_address(rd_effective_address), .wr_req(wr_req), .wr_word(wr_word),
  .wr_effective_address(wr_effective_address), .pc(pc), .prog_addr(prog_addr),
  .prog_region(prog_region), .prog_ok(prog_ok), .rd_data(rd_data), .rd_region(rd_region),
  .psv_rd(psv_rd), .ram_we_lo(ram_we_lo), .ram_we_hi(ram_we_hi),
  .addr_err_trap(addr_err_trap));
